// [design/wds_pkg.sv]
// Shared constants and carrier types for the watchdog and clock supervisor.
package wds_pkg;

    // ********************************************************
    // Clock and timing.
    // ********************************************************
    localparam int CLK_NS      = 50;
    // Reset-output pulse: a least time, so it rounds up to whole cycles.
    localparam int RESET_OUTPUT_PIN_NS   = 1000;
    localparam int RESET_OUTPUT_PIN_CYC  = (RESET_OUTPUT_PIN_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [4:0] RESET_OUTPUT_PIN_LOAD = RESET_OUTPUT_PIN_CYC[4:0];
    // Link edges counted without any oscillator edge before failure is declared.
    localparam logic [3:0] OSC_MISS_LIMIT = 4'h8;

    // ********************************************************
    // Register map, byte addresses.
    // ********************************************************
    localparam int AW = 12;
    localparam logic [AW-1:0] OFS_CTRL   = 12'h000;
    localparam logic [AW-1:0] OFS_RELOAD = 12'h004;
    localparam logic [AW-1:0] OFS_CMD    = 12'h008;
    localparam logic [AW-1:0] OFS_STAT   = 12'h00c;

    // Control register fields.
    localparam int CTRL_WDT_DIS = 0;
    localparam int CTRL_PSEL    = 1;
    localparam int CTRL_OWD_DIS = 3;
    localparam int CTRL_PRESC   = 4;
    // Command register fields (write-one actions).
    localparam int CMD_SERVICE  = 0;
    localparam int CMD_END_OF_INIT_INSTRUCTION    = 1;
    // Status register fields; the counter sits in bits 15:0.
    localparam int STAT_INIT    = 16;
    localparam int STAT_FAIL    = 17;
    localparam int STAT_WDRST   = 18;
    localparam int STAT_WDT_EN  = 19;

    // Count clock divider selection; reset gives 5.24 ms at a 25 MHz system clock.
    typedef enum logic [1:0] {
        WDS_DIV2   = 2'b00,
        WDS_DIV4   = 2'b01,
        WDS_DIV128 = 2'b10,
        WDS_DIV256 = 2'b11
    } wds_div_e;

    localparam wds_div_e   PSEL_RST   = WDS_DIV2;
    localparam logic [7:0] RELOAD_RST = 8'h00;
    localparam logic [7:0] MASK_DIV2   = 8'h01;
    localparam logic [7:0] MASK_DIV4   = 8'h03;
    localparam logic [7:0] MASK_DIV128 = 8'h7f;
    localparam logic [7:0] MASK_DIV256 = 8'hff;
    localparam logic [15:0] CNT_MAX    = 16'hffff;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ********************************************************
    // AXI4-Lite carriers.
    // ********************************************************
    typedef struct packed {
        logic          awvalid;
        logic [AW-1:0] awaddr;
        logic          wvalid;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          bready;
        logic          arvalid;
        logic [AW-1:0] araddr;
        logic          rready;
    } wds_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } wds_axi_rsp_s;

endpackage

// [design/wds_sync.sv]
// Two-flop synchronisers for pins that arrive from outside the clock domain.
`timescale 1ns/100ps
module wds_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             aclk,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // ********************************************************
    // One chain per bit; the first stage feeds only the second.
    // ********************************************************
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge aclk) begin
            meta_reg[i] <= async_in[i];
            sync_out[i] <= meta_reg[i];
        end
    end

endmodule

// [design/wds_top.sv]
// Watchdog counter and oscillator supervisor with an AXI4-Lite register port.
`timescale 1ns/100ps
// How it works
// (R01) Watchdog runs after reset; disable accepted only before end of init.
// (R02) Counter overflow raises internal reset and drives reset output low.
// (R03) 16-bit up-counter ticking at system clock divided by 2, 4, 128 or 256.
// (R04) Each service without a same-cycle overflow loads the counter high byte from the reload value.
// (R05) Each service also clears the counter low byte.
// (R06) Reset divider and reload give 5.24 ms at a 25 MHz clock.
// (R07) Oscillator edges are checked against independent link clock edges.
// (R08) Missing oscillator edges raise the request and switch the CPU to link clock.
// (R09) Direct mode uses link base clock; prescaler mode divides it by two.
// (R10) Switch back to oscillator happens only through a hardware reset.
// (R11) Supervisor disabled: link clock idle, oscillator clock used, no requests; an earlier switch to link clock is kept.
// (R12) Disable bit loads the inverted read-strobe level when reset ends.
// (R13) External logic holds read strobe low in reset to disable the supervisor.
module wds_top (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire wds_pkg::wds_axi_req_s axi_req,
    output wds_pkg::wds_axi_rsp_s      axi_rsp,
    input  wire logic                  osc_clk_in,
    input  wire logic                  pll_clk_in,
    input  wire logic                  read_strobe_in,
    output logic                       reset_output_pin_n,
    output logic                       internal_reset,
    output logic                       supervisor_irq,
    output logic                       pll_enable,
    output logic                       cpu_clk_pll,
    output logic                       pll_div2
);
    import wds_pkg::*;

    typedef struct packed {
        wds_axi_rsp_s  rsp;
        logic          aw_have;
        logic [AW-1:0] aw_addr;
        logic          w_have;
        logic [31:0]   w_data;
        logic [3:0]    w_strb;
        logic [7:0]    pre;
        logic [15:0]   cnt;
        wds_div_e      psel;
        logic [7:0]    reload;
        logic          wdt_en;
        logic          init_done;
        logic          wd_rst_flag;
        logic [4:0]    rst_cnt;
        logic          int_rst;
        logic          owd_dis;
        logic          presc_mode;
        logic          strap_pend;
        logic          osc_last;
        logic          pll_last;
        logic [3:0]    miss;
        logic          clk_pll;
        logic          irq;
        logic          rst_out_n;
        logic          pll_en;
        logic          div2;
    } wds_state_s;

    wds_state_s r;
    wds_state_s n;

    logic [2:0] pins_s;
    logic       osc_s;
    logic       pll_s;
    logic       rd_s;
    logic [7:0] pre_mask;
    logic       tick;
    logic       ovf;
    logic       wr_fire;
    logic       service;
    logic       fail_det;
    logic [31:0] rd_word;
    logic       rd_ok;

    // ********************************************************
    // Pin synchronisers.
    // ********************************************************
    wds_sync #(.WIDTH(3)) u_sync (
        .aclk     (aclk),
        .async_in ({read_strobe_in, pll_clk_in, osc_clk_in}),
        .sync_out (pins_s)
    );
    assign osc_s = pins_s[0];
    assign pll_s = pins_s[1];
    assign rd_s  = pins_s[2];

    // ********************************************************
    // Count clock divider and overflow detect.
    // ********************************************************
    // The enable pulse comes once every 2, 4, 128 or 256 cycles.
    always_comb begin
        unique case (r.psel)
            WDS_DIV2:   pre_mask = MASK_DIV2;
            WDS_DIV4:   pre_mask = MASK_DIV4;
            WDS_DIV128: pre_mask = MASK_DIV128;
            WDS_DIV256: pre_mask = MASK_DIV256;
        endcase
    end
    assign tick    = ((r.pre & pre_mask) == pre_mask); // [R03]
    assign ovf     = r.wdt_en && tick && (r.cnt == CNT_MAX); // [R02]
    assign wr_fire = r.aw_have && r.w_have && !r.rsp.bvalid;
    assign service = wr_fire && (r.aw_addr == OFS_CMD) && r.w_strb[0]
                     && r.w_data[CMD_SERVICE];
    // A link edge with no oscillator edge for too long means a dead oscillator.
    assign fail_det = !r.owd_dis && !r.clk_pll && (r.miss == OSC_MISS_LIMIT); // [R07]

    // ********************************************************
    // Read data mux; unmapped addresses answer with an error.
    // ********************************************************
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        unique case (r.rsp.arready ? axi_req.araddr : OFS_STAT)
            OFS_CTRL: begin
                rd_word[CTRL_WDT_DIS]         = !r.wdt_en;
                rd_word[CTRL_PSEL +: 2]       = r.psel;
                rd_word[CTRL_OWD_DIS]         = r.owd_dis;
                rd_word[CTRL_PRESC]           = r.presc_mode;
            end
            OFS_RELOAD: rd_word[7:0] = r.reload;
            OFS_CMD:    rd_word = 32'h0000_0000;
            OFS_STAT: begin
                rd_word[15:0]       = r.cnt;
                rd_word[STAT_INIT]  = r.init_done;
                rd_word[STAT_FAIL]  = r.clk_pll;
                rd_word[STAT_WDRST] = r.wd_rst_flag;
                rd_word[STAT_WDT_EN] = r.wdt_en;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    // ********************************************************
    // Next-state logic.
    // ********************************************************
    always_comb begin
        n = r;
        n.int_rst = 1'b0;
        n.irq     = 1'b0;
        n.pre     = r.pre + 8'h01;
        n.osc_last = osc_s;
        n.pll_last = pll_s;

        // Write channel: address and data are taken in either order.
        if (axi_req.awvalid && r.rsp.awready) begin
            n.aw_have = 1'b1;
            n.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && r.rsp.wready) begin
            n.w_have = 1'b1;
            n.w_data = axi_req.wdata;
            n.w_strb = axi_req.wstrb;
        end
        if (wr_fire) begin
            n.aw_have    = 1'b0;
            n.w_have     = 1'b0;
            n.rsp.bvalid = 1'b1;
            n.rsp.bresp  = (r.aw_addr == OFS_CTRL || r.aw_addr == OFS_RELOAD
                            || r.aw_addr == OFS_CMD) ? RESP_OKAY : RESP_SLVERR;
            if (r.w_strb[0]) begin
                unique case (r.aw_addr)
                    OFS_CTRL: begin
                        // Disabling is locked out once initialisation ends.
                        if (!r.init_done && r.w_data[CTRL_WDT_DIS]) begin
                            n.wdt_en = 1'b0; // [R01]
                        end
                        n.psel       = wds_div_e'(r.w_data[CTRL_PSEL +: 2]);
                        n.owd_dis    = r.w_data[CTRL_OWD_DIS];
                        n.presc_mode = r.w_data[CTRL_PRESC];
                    end
                    OFS_RELOAD: n.reload = r.w_data[7:0];
                    OFS_CMD: begin
                        if (r.w_data[CMD_END_OF_INIT_INSTRUCTION]) begin
                            n.init_done = 1'b1; // [R01]
                        end
                    end
                    default: n.reload = r.reload;
                endcase
            end
        end
        if (r.rsp.bvalid && axi_req.bready) begin
            n.rsp.bvalid = 1'b0;
        end
        n.rsp.awready = !n.aw_have && !n.rsp.bvalid;
        n.rsp.wready  = !n.w_have && !n.rsp.bvalid;

        // Read channel: one read in flight, answered on the next cycle.
        if (axi_req.arvalid && r.rsp.arready) begin
            n.rsp.arready = 1'b0;
            n.rsp.rvalid  = 1'b1;
            n.rsp.rdata   = rd_word;
            n.rsp.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (r.rsp.rvalid && axi_req.rready) begin
            n.rsp.rvalid  = 1'b0;
            n.rsp.arready = 1'b1;
        end

        // Watchdog counter: service wins over a tick in the same cycle unless that tick overflows.
        if (service) begin
            n.cnt = {r.reload, 8'h00}; // [R04] [R05]
        end else if (r.wdt_en && tick) begin
            n.cnt = r.cnt + 16'h0001; // [R03]
        end

        // Reset-output pulse count.
        if (r.rst_cnt != 5'h00) begin
            n.rst_cnt = r.rst_cnt - 5'h01;
        end

        // Oscillator supervision, counting link edges between oscillator edges.
        if (osc_s != r.osc_last) begin
            n.miss = 4'h0;
        end else if (pll_s && !r.pll_last && r.miss != OSC_MISS_LIMIT) begin
            n.miss = r.miss + 4'h1; // [R07]
        end
        if (fail_det) begin
            n.clk_pll = 1'b1; // [R08] [R10]
            n.irq     = 1'b1; // [R08]
        end

        // Strap catch on the first cycle after reset release.
        if (r.strap_pend) begin
            n.strap_pend = 1'b0;
            n.owd_dis    = !rd_s; // [R12] [R13]
        end

        // Overflow acts as a hardware reset of the supervised chip.
        if (ovf) begin
            n.int_rst     = 1'b1; // [R02]
            n.rst_cnt     = RESET_OUTPUT_PIN_LOAD; // [R02]
            n.wd_rst_flag = 1'b1;
            n.cnt         = 16'h0000;
            n.pre         = 8'h00;
            n.wdt_en      = 1'b1; // [R01]
            n.init_done   = 1'b0;
            n.psel        = PSEL_RST; // [R06]
            n.reload      = RELOAD_RST; // [R06]
            n.clk_pll     = 1'b0; // [R10]
            n.miss        = 4'h0;
        end

        // Pin levels are registered from the settled next state so no pin glitches.
        n.rst_out_n = (n.rst_cnt == 5'h00); // [R02]
        n.pll_en    = !n.owd_dis; // [R11]
        n.div2      = n.clk_pll && n.presc_mode; // [R09]
    end

    // ********************************************************
    // State register with synchronous reset.
    // ********************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r               <= '0;
            r.rsp.awready   <= 1'b1;
            r.rsp.wready    <= 1'b1;
            r.rsp.arready   <= 1'b1;
            r.psel          <= PSEL_RST; // [R06]
            r.reload        <= RELOAD_RST; // [R06]
            r.wdt_en        <= 1'b1; // [R01]
            r.strap_pend    <= 1'b1;
            r.rst_out_n     <= 1'b1;
            r.pll_en        <= 1'b1; // [R11]
        end else begin
            r <= n;
        end
    end

    // ********************************************************
    // Outputs, all taken from the state register.
    // ********************************************************
    assign axi_rsp            = r.rsp;
    assign reset_output_pin_n = r.rst_out_n; // [R02]
    assign internal_reset     = r.int_rst;
    assign supervisor_irq     = r.irq;
    // With supervision off the link clock is idled and no switch-over occurs; an earlier switch-over is kept.
    assign pll_enable  = r.pll_en; // [R11]
    assign cpu_clk_pll = r.clk_pll; // [R08]
    // The halved base clock is only meaningful after a switch-over.
    assign pll_div2    = r.div2; // [R09]

    // ********************************************************
    // Checks.
    // ********************************************************
    a_service_reload: assert property (@(posedge aclk) disable iff (!aresetn) // [R04]
        service && !ovf |=> r.cnt == {$past(r.reload), 8'h00})
        else $error("Service did not load reload byte with zero low byte.");

    a_count_step: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
        r.wdt_en && tick && !service && !ovf |=> r.cnt == $past(r.cnt) + 16'h0001)
        else $error("Watchdog counter did not advance on a tick.");

    a_div2_ticks: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
        r.psel == WDS_DIV2 && tick |=> !tick)
        else $error("Divide-by-two enable came on two cycles running.");

    a_ovf_reset_output_pin: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
        ovf |=> internal_reset && !reset_output_pin_n ##1 !reset_output_pin_n[*8])
        else $error("Overflow did not hold the reset output low.");

    a_disable_lock: assert property (@(posedge aclk) disable iff (!aresetn) // [R01]
        r.init_done && r.wdt_en |=> r.wdt_en)
        else $error("Watchdog was disabled after end of initialisation.");

    a_reset_defaults: assert property (@(posedge aclk) // [R06]
        $rose(aresetn) |-> r.psel == PSEL_RST && r.reload == RELOAD_RST && r.wdt_en)
        else $error("Watchdog reset settings are wrong.");

    a_osc_switch: assert property (@(posedge aclk) disable iff (!aresetn) // [R08]
        fail_det |=> cpu_clk_pll && supervisor_irq ##1 !supervisor_irq)
        else $error("Oscillator loss did not switch clock and raise request.");

    a_switch_stays: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
        cpu_clk_pll && !ovf |=> cpu_clk_pll)
        else $error("Clock switched back without a reset.");

    a_owd_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
        r.owd_dis && $past(r.owd_dis) |-> !supervisor_irq && !pll_enable)
        else $error("Disabled supervisor raised a request or ran the link clock.");

    a_pll_div: assert property (@(posedge aclk) disable iff (!aresetn) // [R09]
        cpu_clk_pll |-> pll_div2 == r.presc_mode)
        else $error("Switched clock division does not follow the mode.");

    a_strap_load: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
        r.strap_pend |=> r.owd_dis == !$past(rd_s))
        else $error("Supervisor disable did not take the inverted strobe level.");

endmodule

// [tb/tb_top.sv]
// Self-checking testbench for the watchdog and clock supervisor.
`timescale 1ns/100ps
module tb_top;
    import wds_pkg::*;

    // ************************************************************
    // Clock, reset, design and partner.
    // ************************************************************
    logic         aclk;
    logic         aresetn;
    wds_axi_req_s req;
    wds_axi_rsp_s rsp;
    logic         osc_clk, pll_clk, read_strobe, osc_run, strap_low;
    logic         rst_out_n, int_rst, irq, pll_en, cpu_pll, div2;
    int           err_count, checks, irq_cnt, n;
    logic [31:0]  v, w;
    logic [1:0]   r;
    int           divs[4] = '{2, 4, 128, 256};

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    wds_top dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
        .osc_clk_in(osc_clk), .pll_clk_in(pll_clk), .read_strobe_in(read_strobe),
        .reset_output_pin_n(rst_out_n), .internal_reset(int_rst), .supervisor_irq(irq),
        .pll_enable(pll_en), .cpu_clk_pll(cpu_pll), .pll_div2(div2));

    wds_partner partner (.aresetn(aresetn), .pll_enable(pll_en), .osc_run(osc_run),
        .strap_low(strap_low), .osc_clk(osc_clk), .pll_clk(pll_clk), .read_strobe(read_strobe));

    // Counts supervisor request pulses so silent phases can be proven silent.
    always @(posedge aclk) begin
        if (irq === 1'b1) begin
            irq_cnt++;
        end
    end

    // ************************************************************
    // Reporting.
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic give_up();
        err_count++;
        final_report();
    endtask

    // ************************************************************
    // Bus master tasks; every wait is bounded.
    // ************************************************************
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
        int k;
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= 4'hf;
        req.bready  <= 1'b1;
        for (k = 0; k < 200; k++) begin
            @(posedge aclk);
            if (rsp.bvalid === 1'b1) begin
                resp = rsp.bresp;
                // Ready stays high so back-to-back calls never drive it twice at once.
                break;
            end
            if (req.awvalid && rsp.awready === 1'b1) begin
                req.awvalid <= 1'b0;
            end
            if (req.wvalid && rsp.wready === 1'b1) begin
                req.wvalid <= 1'b0;
            end
        end
        if (k == 200) begin
            give_up();
        end
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
        int k;
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        for (k = 0; k < 200; k++) begin
            @(posedge aclk);
            if (rsp.rvalid === 1'b1) begin
                d = rsp.rdata;
                resp = rsp.rresp;
                break;
            end
            if (req.arvalid && rsp.arready === 1'b1) begin
                req.arvalid <= 1'b0;
            end
        end
        if (k == 200) begin
            give_up();
        end
    endtask

    // Waits for the internal reset pulse (sel 0) or the supervisor request (sel 1).
    task automatic wait_ev(input bit sel, input int lim, output int cnt);
        for (cnt = 0; cnt < lim; cnt++) begin
            @(posedge aclk);
            if ((sel ? irq : int_rst) === 1'b1) begin
                break;
            end
        end
        if (cnt == lim) begin
            give_up();
        end
    endtask

    // Reset for four cycles; the strap is applied while reset is held.
    task automatic do_reset(input logic strap);
        strap_low <= strap;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        @(posedge aclk);
    endtask

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        req = '0;
        aresetn = 1'b0;
        osc_run = 1'b1;
        strap_low = 1'b0;
        do_reset(1'b0);
        // Reset state: watchdog running, default divider and reload.
        rd(OFS_STAT, v, r);
        check(v[19:16], 32'h8);
        rd(OFS_CTRL, v, r);
        check(v, 32'(PSEL_RST) << CTRL_PSEL);
        rd(OFS_RELOAD, v, r);
        check(v, {24'h0, RELOAD_RST});
        check(32'(65536 * divs[int'(PSEL_RST)] * 40 / 10000), 32'd524);
        check(pll_en, 1'b1);
        rd(12'h010, v, r);
        check(v, 32'h0);
        check(r, RESP_SLVERR);
        wr(OFS_STAT, 32'h0, r);
        check(r, RESP_SLVERR);
        $display("test reset_state done");
        // Every divider: service reloads the high byte and clears the low byte.
        foreach (divs[p]) begin
            wr(OFS_CTRL, 32'(p) << CTRL_PSEL, r);
            wr(OFS_RELOAD, 32'h80, r);
            wr(OFS_CMD, 32'h1 << CMD_SERVICE, r);
            repeat (512) @(posedge aclk);
            rd(OFS_STAT, v, r);
            n = 32'h8000 + 512 / divs[p];
            check((v[15:0] >= n && v[15:0] <= n + 4) ? n : v[15:0], n);
        end
        $display("test dividers done");
        // Overflow: internal reset pulse and a timed low on the reset output.
        wr(OFS_CTRL, 32'h0, r);
        wr(OFS_RELOAD, 32'hff, r);
        wr(OFS_CMD, 32'h1 << CMD_SERVICE, r);
        wait_ev(1'b0, 700, n);
        check((n >= 500 && n <= 520) ? 512 : n, 512);
        check(rst_out_n, 1'b0);
        n = 1;
        @(posedge aclk);
        check(int_rst, 1'b0);
        while (rst_out_n === 1'b0 && n < 100) begin
            n++;
            @(posedge aclk);
        end
        check(n, RESET_OUTPUT_PIN_CYC);
        rd(OFS_STAT, v, r);
        check(v[19:16], 32'hc);
        rd(OFS_CTRL, v, r);
        check(v, 32'(PSEL_RST) << CTRL_PSEL);
        // After end of init a disable request is ignored.
        wr(OFS_CMD, 32'h1 << CMD_END_OF_INIT_INSTRUCTION, r);
        wr(OFS_CTRL, 32'h1 << CTRL_WDT_DIS, r);
        rd(OFS_STAT, v, r);
        check(v[19:16], 32'hd);
        $display("test overflow done");
        // Before end of init the watchdog can be stopped.
        do_reset(1'b0);
        wr(OFS_CTRL, (32'h1 << CTRL_WDT_DIS) | (32'h1 << CTRL_PRESC), r);
        rd(OFS_STAT, w, r);
        check(w[19], 1'b0);
        repeat (200) @(posedge aclk);
        rd(OFS_STAT, v, r);
        check(v[15:0], w[15:0]);
        $display("test disable done");
        // Oscillator loss in prescaler mode, then recovery only through reset.
        check(cpu_pll, 1'b0);
        check(32'(irq_cnt), 32'h0);
        osc_run <= 1'b0;
        wait_ev(1'b1, 200, n);
        @(posedge aclk);
        check({irq, cpu_pll, div2}, 3'b011);
        rd(OFS_STAT, v, r);
        check(v[17], 1'b1);
        osc_run <= 1'b1;
        repeat (200) @(posedge aclk);
        wr(OFS_CTRL, (32'h1 << CTRL_WDT_DIS) | (32'h1 << CTRL_OWD_DIS), r);
        repeat (3) @(posedge aclk);
        check({cpu_pll, div2}, 2'b10);
        check(32'(irq_cnt), 32'h1);
        do_reset(1'b0);
        check(cpu_pll, 1'b0);
        $display("test supervisor done");
        // Strap low during reset disables the supervisor.
        do_reset(1'b1);
        check(pll_en, 1'b0);
        rd(OFS_CTRL, v, r);
        check(v[CTRL_OWD_DIS], 1'b1);
        osc_run <= 1'b0;
        repeat (300) @(posedge aclk);
        check(cpu_pll, 1'b0);
        check(32'(irq_cnt), 32'h1);
        osc_run <= 1'b1;
        $display("test strap done");
        final_report();
    end
endmodule

// [tb/wds_partner.sv]
// Model of the oscillator, the link clock source and the read-strobe strap circuit.
`timescale 1ns/100ps
module wds_partner (
    input  wire logic aresetn,
    input  wire logic pll_enable,
    input  wire logic osc_run,
    input  wire logic strap_low,
    output logic      osc_clk,
    output logic      pll_clk,
    output logic      read_strobe
);
    // Oscillator edges every 100 ns; a stopped oscillator simply holds its level.
    initial begin
        osc_clk = 1'b0;
        forever #100 osc_clk = osc_run ? ~osc_clk : osc_clk;
    end

    // Link clock with an unrelated period; it stands still while disabled.
    initial begin
        pll_clk = 1'b0;
        forever #37 pll_clk = (pll_enable === 1'b1) ? ~pll_clk : 1'b0;
    end

    // Strap pulls the strobe low only while reset is held, otherwise the pull-up wins.
    assign read_strobe = (!aresetn && strap_low) ? 1'b0 : 1'b1;
endmodule
